// ### design/timer_counter_match_capture.sv
// Functional notes
// - a 32-bit count is advanced through a programmable 32-bit prescaler.
// - software selects counting of mclk cycles or of external clock edges.
// - two 32-bit capture channels snapshot the count on input transitions.
// - each capture channel may raise an interrupt, enabled per channel.
// - four 32-bit match registers are compared continuously with the count.
// - a match may keep counting while optionally raising an interrupt.
// - a match may halt counting, optionally raising an interrupt.
// - a match may return the count to zero, optionally raising an interrupt.
// - four match outputs go low, high, toggle or hold on their match.
// - at most two match channels may issue a timed dma request.
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
module timer_counter_match_capture #(
  parameter int NUM_MATCH = 4,
  parameter int NUM_CAPT  = 2
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 ext_clk_i,
  input  wire logic [NUM_CAPT-1:0]  capt_i,
  output logic      [NUM_MATCH-1:0] match_o,
  output logic      [1:0]           dma_req_o,
  output logic                      irq_o
);
  logic                 acc;
  logic                 acc_wr;
  logic [31:0]          ctrl_q;
  logic [31:0]          count_q;
  logic [31:0]          presc_q;
  logic [31:0]          presc_cnt_q;
  logic [11:0]          match_ctrl_q;
  logic [5:0]           capt_ctrl_q;
  logic [7:0]           ext_ctrl_q;
  logic [31:0]          match_q [NUM_MATCH];
  logic [31:0]          capt_q [NUM_CAPT];
  logic [5:0]           irq_stat_q;
  logic [5:0]           irq_mask_q;
  logic [3:0]           dma_ctrl_q;
  logic [NUM_MATCH-1:0] match_lvl_q;
  logic [1:0]           dma_req_q;
  logic [NUM_MATCH-1:0] match_hit;
  logic [NUM_MATCH-1:0] match_edge_q;
  logic [NUM_CAPT-1:0]  capt_ev;
  logic [NUM_CAPT-1:0]  capt_rise;
  logic [NUM_CAPT-1:0]  capt_fall;
  logic                 ext_rise;
  logic                 ext_fall;
  logic                 src_tick;
  logic                 presc_wrap;
  logic                 any_stop;
  logic                 any_rst;
  logic                 wr_ctrl;

  // address decode helper used by every register write
  function automatic logic wr_at(input logic [5:0] ofs);
    return acc_wr && (avs_address == ofs);
  endfunction

  tmr_avalon_regs u_bus (
    .mclk_i         (mclk_i),
    .rst_n_i        (rst_n_i),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_waitrequest(avs_waitrequest),
    .acc_o          (acc),
    .acc_wr_o       (acc_wr)
  );

  // external count input through the synchroniser
  tmr_sync_edge u_ext_sync (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(ext_clk_i),
    .level_o(),
    .rise_o (ext_rise),
    .fall_o (ext_fall)
  );

  // capture inputs through their synchronisers
  for (genvar c = 0; c < NUM_CAPT; c++) begin : g_capt_sync
    tmr_sync_edge u_sync (
      .mclk_i (mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(capt_i[c]),
      .level_o(),
      .rise_o (capt_rise[c]),
      .fall_o (capt_fall[c])
    );
  end

  assign wr_ctrl = wr_at(tmr_pkg::OFS_CTRL);

  // count source selection
  always_comb begin
    unique case (ctrl_q[tmr_pkg::CTRL_MODE_LSB +: 2])
      tmr_pkg::SRC_CLK:      src_tick = 1'b1;
      tmr_pkg::SRC_EXT_RISE: src_tick = ext_rise;
      tmr_pkg::SRC_EXT_FALL: src_tick = ext_fall;
      tmr_pkg::SRC_EXT_BOTH: src_tick = ext_rise | ext_fall;
    endcase
  end

  // continuous compare; a hit counts once per count value, so a halted
  // count does not re-fire its match every cycle
  for (genvar m = 0; m < NUM_MATCH; m++) begin : g_match
    assign match_hit[m] = (count_q == match_q[m]) & ~match_edge_q[m];
  end

  always_comb begin
    any_stop = 1'b0;
    any_rst  = 1'b0;
    for (int m = 0; m < NUM_MATCH; m++) begin
      any_stop |= match_hit[m] & match_ctrl_q[m*3 + tmr_pkg::MC_STOP_BIT];
      any_rst  |= match_hit[m] & match_ctrl_q[m*3 + tmr_pkg::MC_RST_BIT];
    end
  end

  // remember which compares already fired for this count value
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      match_edge_q <= '0;
    end else begin
      for (int m = 0; m < NUM_MATCH; m++) begin
        match_edge_q[m] <= (count_q == match_q[m]);
      end
    end
  end

  assign presc_wrap = src_tick && (presc_cnt_q >= presc_q);

  // control register; a stop match clears the enable bit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= tmr_pkg::RST_ZERO;
    end else if (any_stop) begin
      ctrl_q <= wr_ctrl ? avs_writedata : ctrl_q;
      ctrl_q[tmr_pkg::CTRL_EN_BIT] <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_q <= avs_writedata;
    end
  end

  // prescaler: divides the selected source, restarts at its limit
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      presc_cnt_q <= tmr_pkg::RST_ZERO;
    end else if (ctrl_q[tmr_pkg::CTRL_RST_BIT] || any_rst) begin
      presc_cnt_q <= tmr_pkg::RST_ZERO;
    end else if (ctrl_q[tmr_pkg::CTRL_EN_BIT] && src_tick) begin
      if (presc_wrap) begin
        presc_cnt_q <= tmr_pkg::RST_ZERO;
      end else begin
        presc_cnt_q <= presc_cnt_q + 32'h0000_0001;
      end
    end
  end

  // main count; reset match wins over the advance, stop freezes it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      count_q <= tmr_pkg::RST_ZERO;
    end else if (ctrl_q[tmr_pkg::CTRL_RST_BIT] || any_rst) begin
      count_q <= tmr_pkg::RST_ZERO;
    end else if (any_stop) begin
      count_q <= count_q;
    end else if (ctrl_q[tmr_pkg::CTRL_EN_BIT] && presc_wrap) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // plain configuration registers
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      presc_q      <= tmr_pkg::RST_ZERO;
      match_ctrl_q <= 12'h000;
      capt_ctrl_q  <= 6'h00;
      ext_ctrl_q   <= 8'h00;
      irq_mask_q   <= 6'h00;
      dma_ctrl_q   <= 4'h0;
      for (int m = 0; m < NUM_MATCH; m++) begin
        match_q[m] <= tmr_pkg::RST_ZERO;
      end
    end else begin
      if (wr_at(tmr_pkg::OFS_PRESC)) begin
        presc_q <= avs_writedata;
      end
      if (wr_at(tmr_pkg::OFS_MATCH_CTRL)) begin
        match_ctrl_q <= avs_writedata[11:0];
      end
      if (wr_at(tmr_pkg::OFS_CAPT_CTRL)) begin
        capt_ctrl_q <= avs_writedata[5:0];
      end
      if (wr_at(tmr_pkg::OFS_EXT_CTRL)) begin
        ext_ctrl_q <= avs_writedata[7:0];
      end
      if (wr_at(tmr_pkg::OFS_IRQ_MASK)) begin
        irq_mask_q <= avs_writedata[5:0];
      end
      if (wr_at(tmr_pkg::OFS_DMA_CTRL)) begin
        dma_ctrl_q <= avs_writedata[3:0];
      end
      for (int m = 0; m < NUM_MATCH; m++) begin
        if (wr_at(tmr_pkg::OFS_MATCH0 + 6'(4*m))) begin
          match_q[m] <= avs_writedata;
        end
      end
    end
  end

  // capture: snapshot the count on the selected edges
  for (genvar c = 0; c < NUM_CAPT; c++) begin : g_capt
    assign capt_ev[c] =
      (capt_rise[c] & capt_ctrl_q[c*3 + tmr_pkg::CC_RISE_BIT]) |
      (capt_fall[c] & capt_ctrl_q[c*3 + tmr_pkg::CC_FALL_BIT]);
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
        capt_q[c] <= tmr_pkg::RST_ZERO;
      end else if (capt_ev[c]) begin
        capt_q[c] <= count_q;
      end
    end
  end

  // sticky status; an event in the read-clear cycle stays set, and only
  // bits the read reported are cleared, so an event landing during the
  // wait cycle (after read data was loaded) is not lost
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= 6'h00;
    end else begin
      for (int m = 0; m < NUM_MATCH; m++) begin
        if (match_hit[m] && match_ctrl_q[m*3 + tmr_pkg::MC_IRQ_BIT]) begin
          irq_stat_q[m] <= 1'b1;
        end else if (acc && !acc_wr && avs_readdata[m] &&
                     avs_address == tmr_pkg::OFS_IRQ_STAT) begin
          irq_stat_q[m] <= 1'b0;
        end
      end
      for (int c = 0; c < NUM_CAPT; c++) begin
        if (capt_ev[c] && capt_ctrl_q[c*3 + tmr_pkg::CC_IRQ_BIT]) begin
          irq_stat_q[tmr_pkg::IRQ_CAPT_LSB + c] <= 1'b1;
        end else if (acc && !acc_wr &&
                     avs_readdata[tmr_pkg::IRQ_CAPT_LSB + c] &&
                     avs_address == tmr_pkg::OFS_IRQ_STAT) begin
          irq_stat_q[tmr_pkg::IRQ_CAPT_LSB + c] <= 1'b0;
        end
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // match outputs; software may also preset the levels
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      match_lvl_q <= '0;
    end else begin
      for (int m = 0; m < NUM_MATCH; m++) begin
        if (match_hit[m]) begin
          unique case (ext_ctrl_q[m*2 +: 2])
            tmr_pkg::EXT_NONE:   match_lvl_q[m] <= match_lvl_q[m];
            tmr_pkg::EXT_LOW:    match_lvl_q[m] <= 1'b0;
            tmr_pkg::EXT_HIGH:   match_lvl_q[m] <= 1'b1;
            tmr_pkg::EXT_TOGGLE: match_lvl_q[m] <= ~match_lvl_q[m];
          endcase
        end else if (wr_at(tmr_pkg::OFS_EXT_CTRL)) begin
          match_lvl_q[m] <= avs_writedata[tmr_pkg::EXT_LVL_LSB + m];
        end
      end
    end
  end

  assign match_o = match_lvl_q;

  // dma: only match 0 and match 1 have a request line
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dma_req_q <= 2'b00;
    end else begin
      for (int d = 0; d < 2; d++) begin
        if (match_hit[d] && dma_ctrl_q[d]) begin
          dma_req_q[d] <= 1'b1;
        end else if (dma_ctrl_q[2 + d]) begin
          dma_req_q[d] <= 1'b0;
        end else if (wr_at(tmr_pkg::OFS_DMA_CTRL)) begin
          dma_req_q[d] <= 1'b0;
        end
      end
    end
  end

  assign dma_req_o = dma_req_q;

  // registered read data, loaded during the wait cycle
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      avs_readdata <= tmr_pkg::RST_ZERO;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        tmr_pkg::OFS_IRQ_STAT:   avs_readdata <= {26'h0, irq_stat_q};
        tmr_pkg::OFS_CTRL:       avs_readdata <= ctrl_q;
        tmr_pkg::OFS_COUNT:      avs_readdata <= count_q;
        tmr_pkg::OFS_PRESC:      avs_readdata <= presc_q;
        tmr_pkg::OFS_PRESC_CNT:  avs_readdata <= presc_cnt_q;
        tmr_pkg::OFS_MATCH_CTRL: avs_readdata <= {20'h0, match_ctrl_q};
        tmr_pkg::OFS_CAPT_CTRL:  avs_readdata <= {26'h0, capt_ctrl_q};
        tmr_pkg::OFS_EXT_CTRL:
          avs_readdata <= {20'h0, match_lvl_q, ext_ctrl_q};
        tmr_pkg::OFS_MATCH0:     avs_readdata <= match_q[0];
        6'h24:                   avs_readdata <= match_q[1];
        6'h28:                   avs_readdata <= match_q[2];
        6'h2c:                   avs_readdata <= match_q[3];
        tmr_pkg::OFS_CAPT0:      avs_readdata <= capt_q[0];
        6'h34:                   avs_readdata <= capt_q[1];
        tmr_pkg::OFS_IRQ_MASK:   avs_readdata <= {26'h0, irq_mask_q};
        tmr_pkg::OFS_DMA_CTRL:   avs_readdata <= {28'h0, dma_ctrl_q};
        default:                 avs_readdata <= tmr_pkg::UNMAPPED_DATA;
      endcase
    end
  end
endmodule

// ### design/tmr_pkg.sv
package tmr_pkg;
  // register word offsets (byte addresses on the avalon slave)
  localparam logic [5:0] OFS_IRQ_STAT   = 6'h00;
  localparam logic [5:0] OFS_CTRL       = 6'h04;
  localparam logic [5:0] OFS_COUNT      = 6'h08;
  localparam logic [5:0] OFS_PRESC      = 6'h0c;
  localparam logic [5:0] OFS_PRESC_CNT  = 6'h10;
  localparam logic [5:0] OFS_MATCH_CTRL = 6'h14;
  localparam logic [5:0] OFS_CAPT_CTRL  = 6'h18;
  localparam logic [5:0] OFS_EXT_CTRL   = 6'h1c;
  localparam logic [5:0] OFS_MATCH0     = 6'h20;
  localparam logic [5:0] OFS_CAPT0      = 6'h30;
  localparam logic [5:0] OFS_IRQ_MASK   = 6'h38;
  localparam logic [5:0] OFS_DMA_CTRL   = 6'h3c;

  // ctrl fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_RST_BIT  = 1;
  localparam int CTRL_MODE_LSB = 2; // 2 bits: count source select

  // count source encodings
  localparam logic [1:0] SRC_CLK     = 2'h0;
  localparam logic [1:0] SRC_EXT_RISE = 2'h1;
  localparam logic [1:0] SRC_EXT_FALL = 2'h2;
  localparam logic [1:0] SRC_EXT_BOTH = 2'h3;

  // match ctrl: 3 bits per channel
  localparam int MC_IRQ_BIT  = 0;
  localparam int MC_RST_BIT  = 1;
  localparam int MC_STOP_BIT = 2;
  localparam int MC_WIDTH    = 3;

  // capture ctrl: 3 bits per channel
  localparam int CC_RISE_BIT = 0;
  localparam int CC_FALL_BIT = 1;
  localparam int CC_IRQ_BIT  = 2;
  localparam int CC_WIDTH    = 3;

  // external output action: 2 bits per channel, bits 11:8 hold levels
  localparam logic [1:0] EXT_NONE   = 2'h0;
  localparam logic [1:0] EXT_LOW    = 2'h1;
  localparam logic [1:0] EXT_HIGH   = 2'h2;
  localparam logic [1:0] EXT_TOGGLE = 2'h3;
  localparam int EXT_LVL_LSB = 8;

  // irq status layout: bits 3:0 match, bits 5:4 capture
  localparam int IRQ_CAPT_LSB = 4;

  // reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // read answer for unmapped offsets
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ### design/tmr_sync_edge.sv
// two-flop synchroniser followed by edge detection on the second flop
module tmr_sync_edge (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first flop feeds only the second one
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges seen on the synchronised level only
  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;
endmodule

// ### design/tmr_avalon_regs.sv
// avalon-mm slave front end: one wait cycle, then the access completes
module tmr_avalon_regs (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  output logic             avs_waitrequest,
  output logic             acc_o,
  output logic             acc_wr_o
);
  logic pend_q;

  // a request is held one cycle, then acknowledged; a slower but simple
  // timing keeps read data fully registered
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pend_q <= 1'b0;
    end else if (pend_q) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= avs_read | avs_write;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~pend_q;
  assign acc_o           = pend_q & (avs_read | avs_write);
  assign acc_wr_o        = pend_q & avs_write;
endmodule

// ### tb/tmr_pins_model.sv
// far side of the timer: drives the event pins; the ext clock idles low between pulse bursts, capture pins keep their last level
module tmr_pins_model (
  input  wire logic       mclk_i,
  output logic            ext_clk_o,
  output logic      [1:0] capt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ext_clk_o = 1'b0;
  initial capt_o = 2'h0;
  // five cycles a phase, so the two-flop synchroniser never misses a level
  task automatic ext_pulses(input int n);
    repeat (2 * n) begin
      @(posedge mclk_i);
      ext_clk_o <= ~ext_clk_o;
      repeat (4) @(posedge mclk_i);
    end
  endtask
  // new capture levels, then time for sync, capture and interrupt to land
  task automatic capt_set(input logic [1:0] v);
    @(posedge mclk_i);
    capt_o <= v;
    repeat (8) @(negedge mclk_i);
  endtask
endmodule

// ### tb/tmr_checker_assertions.sv
module tmr_checker #(
  parameter int NUM_MATCH = 4
) (
  input wire logic                 mclk_i,
  input wire logic                 rst_n_i,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  input wire logic [NUM_MATCH-1:0] match_o,
  input wire logic [1:0]           dma_req_o,
  input wire logic                 irq_o
);
  logic req;
  logic acc;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // acc marks the last cycle of a transfer, where it takes effect
  assign req = avs_read | avs_write;
  assign acc = req & ~avs_waitrequest;
  sequence new_req;
    req && !$past(req);
  endsequence
  sequence wait_then_done;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  // bus timing, reset state, sticky dma and interrupt release
  acc_wait_a: assert property (new_req |-> wait_then_done)
    else $error("access did not end after one wait cycle");
  idle_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  wait_once_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held two cycles");
  rdata_hold_a: assert property (!(avs_read && avs_waitrequest)
    |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  reset_out_a: assert property (disable iff (1'b0)
    !rst_n_i |=> !irq_o && !(|match_o) && !(|dma_req_o))
    else $error("outputs not cleared by reset");
  dma0_hold_a: assert property (dma_req_o[0] && !avs_write
    |=> dma_req_o[0])
    else $error("dma request 0 dropped without a write");
  dma1_hold_a: assert property (dma_req_o[1] && !avs_write
    |=> dma_req_o[1])
    else $error("dma request 1 dropped without a write");
  irq_drop_a: assert property ($fell(irq_o)
    |-> $past(acc) || $past(acc, 2))
    else $error("interrupt dropped without a register access");
endmodule

bind timer_counter_match_capture tmr_checker #(.NUM_MATCH(NUM_MATCH)) chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .match_o(match_o),
  .dma_req_o(dma_req_o), .irq_o(irq_o)
);

// ### tb/tb_top.sv
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %h not %h", $time, (g), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        ext_clk_i;
  logic [1:0]  capt_i;
  logic [3:0]  match_o;
  logic [1:0]  dma_req_o;
  logic        irq_o;
  logic [31:0] q;
  logic [1:0]  a;
  logic        p;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          l, m0, m1, t0, t1, n;
  // 125 MHz clock and a free cycle count for timing match edges
  always #4 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;

  timer_counter_match_capture uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_clk_i(ext_clk_i),
    .capt_i(capt_i), .match_o(match_o), .dma_req_o(dma_req_o), .irq_o(irq_o)
  );
  tmr_pins_model pins (
    .mclk_i(mclk_i), .ext_clk_o(ext_clk_i), .capt_o(capt_i)
  );

  // one transfer; sampled at the falling edge so no race with the slave
  task automatic bus(input logic wr, input logic [5:0] ad,
                     input logic [31:0] d);
    logic w;
    int k;
    k = 0;
    @(posedge mclk_i);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(negedge mclk_i);
      w = avs_waitrequest;
      q = avs_readdata;
      k++;
      @(posedge mclk_i);
    end while (w !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one wait cycle, then the acknowledge; a hang is cut by the watchdog
    `CHK(k, 2)
  endtask
  task automatic wr(input logic [5:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask
  task automatic rd(input logic [5:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask
  // cycle at which a match pin changes, bounded
  task automatic wait_chg(input int i, output int t);
    logic v;
    int k;
    v = match_o[i];
    k = 0;
    do begin
      @(negedge mclk_i);
      k++;
    end while (match_o[i] === v && k < 2000);
    t = cyc;
    if (k >= 2000) `CHK(match_o[i], ~v)
  endtask
  function automatic logic exp_lvl(input logic [1:0] act, input logic pre);
    return act == tmr_pkg::EXT_LOW ? 1'b0 : act == tmr_pkg::EXT_HIGH ? 1'b1 :
           act == tmr_pkg::EXT_TOGGLE ? ~pre : pre;
  endfunction
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(96242));
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(tmr_pkg::OFS_COUNT);
    `CHK(q, tmr_pkg::RST_ZERO)
    rd(6'h01);
    `CHK(q, tmr_pkg::UNMAPPED_DATA)
    `CHK({irq_o, dma_req_o, match_o}, 7'h00)
    // match 0 runs on, match 1 wraps; both toggle and request dma
    repeat (4) begin
      l = $urandom_range(3);
      m0 = $urandom_range(4, 1);
      m1 = m0 + 1 + $urandom_range(4);
      wr(tmr_pkg::OFS_CTRL, 32'h2);
      wr(tmr_pkg::OFS_PRESC, 32'(l));
      wr(tmr_pkg::OFS_MATCH0, 32'(m0));
      wr(tmr_pkg::OFS_MATCH0 + 6'h04, 32'(m1));
      wr(tmr_pkg::OFS_MATCH_CTRL, 32'h11); // irq on 0, wrap on 1
      wr(tmr_pkg::OFS_EXT_CTRL, 32'h0f);
      wr(tmr_pkg::OFS_DMA_CTRL, 32'h3);
      wr(tmr_pkg::OFS_IRQ_MASK, 32'h1);
      wr(tmr_pkg::OFS_CTRL, 32'h1);
      wait_chg(0, t0);
      wait_chg(1, t1);
      `CHK(t1 - t0, (m1 - m0) * (l + 1))
      `CHK(match_o[1:0], 2'h3)
      `CHK({dma_req_o, irq_o}, 3'h7)
      wr(tmr_pkg::OFS_CTRL, 32'h0);
      wr(tmr_pkg::OFS_DMA_CTRL, 32'h0);
      @(negedge mclk_i);
      `CHK(dma_req_o, 2'h0)
      rd(tmr_pkg::OFS_IRQ_STAT);
      `CHK(q[0], 1'b1)
      rd(tmr_pkg::OFS_IRQ_STAT);
      @(negedge mclk_i);
      `CHK({q, irq_o}, 33'h0)
    end
    // every pin action, judged when the toggling match 1 moves
    for (int j = 0; j < 4; j++) begin
      a = 2'(j);
      p = 1'($urandom_range(1));
      wr(tmr_pkg::OFS_CTRL, 32'h2);
      wr(tmr_pkg::OFS_PRESC, 32'h0);
      wr(tmr_pkg::OFS_MATCH_CTRL, 32'h0);
      wr(tmr_pkg::OFS_MATCH0, 32'h3);
      wr(tmr_pkg::OFS_MATCH0 + 6'h04, 32'h3);
      wr(tmr_pkg::OFS_EXT_CTRL, {23'h0, p, 4'h0, 2'h3, a});
      wr(tmr_pkg::OFS_CTRL, 32'h1);
      wait_chg(1, t1);
      `CHK(match_o[0], exp_lvl(a, p))
    end
    // match 2 halts the count, so captures see a frozen value
    m0 = $urandom_range(20, 5);
    wr(tmr_pkg::OFS_CTRL, 32'h2);
    wr(tmr_pkg::OFS_MATCH0 + 6'h08, 32'(m0));
    wr(tmr_pkg::OFS_MATCH_CTRL, 32'h100);
    wr(tmr_pkg::OFS_CTRL, 32'h1);
    n = 0;
    do begin
      rd(tmr_pkg::OFS_CTRL);
      n++;
    end while (q[0] !== 1'b0 && n < 50);
    `CHK(q[0], 1'b0)
    rd(tmr_pkg::OFS_COUNT);
    `CHK(q, 32'(m0))
    wr(tmr_pkg::OFS_CAPT_CTRL, 32'h15); // rise and irq on 0, fall on 1
    wr(tmr_pkg::OFS_IRQ_MASK, 32'h10);
    rd(tmr_pkg::OFS_IRQ_STAT);
    pins.capt_set(2'h3);
    `CHK(irq_o, 1'b1)
    rd(tmr_pkg::OFS_CAPT0);
    `CHK(q, 32'(m0))
    rd(tmr_pkg::OFS_CAPT0 + 6'h04);
    `CHK(q, tmr_pkg::RST_ZERO)
    rd(tmr_pkg::OFS_IRQ_STAT);
    wr(tmr_pkg::OFS_IRQ_MASK, 32'h30);
    pins.capt_set(2'h0);
    `CHK(irq_o, 1'b0)
    rd(tmr_pkg::OFS_CAPT0 + 6'h04);
    `CHK(q, 32'(m0))
    // external edges counted under each edge mode
    wr(tmr_pkg::OFS_MATCH_CTRL, 32'h0);
    for (int s = 1; s < 4; s++) begin
      n = $urandom_range(5, 2);
      wr(tmr_pkg::OFS_CTRL, 32'h2);
      wr(tmr_pkg::OFS_CTRL, {28'h0, 2'(s), 2'h1});
      pins.ext_pulses(n);
      rd(tmr_pkg::OFS_COUNT);
      `CHK(q, 32'(2'(s) == tmr_pkg::SRC_EXT_BOTH ? 2 * n : n))
    end
    end_of_test();
  end
  // the tests need under a thousand cycles; this cuts a hang short
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_fail++;
    end_of_test();
  end
endmodule
